// [hw/lcd_cmd_pkg.sv]
// Shared constants for the display controller command link and its host bridge
package lcd_cmd_pkg;
  localparam int unsigned COLS           = 240;
  localparam int unsigned PAGES          = 16;
  localparam logic [7:0]  COL_LAST       = 8'hEF;
  localparam logic [7:0]  COL_FIRST      = 8'h00;
  localparam logic [3:0]  PAGE_LAST      = 4'hF;
  localparam logic [3:0]  PAGE_FIRST     = 4'h0;
  localparam logic [3:0]  PAGE_ONE       = 4'h1;
  localparam logic [3:0]  COL_HI_MAX     = 4'hE;
  // Opcode masks and values
  localparam logic [7:0]  M_COL_LO = 8'hF0, V_COL_LO = 8'h00;
  localparam logic [7:0]  M_COL_HI = 8'hF0, V_COL_HI = 8'h10;
  localparam logic [7:0]  M_MUX    = 8'hF8, V_MUX    = 8'h20;
  localparam logic [7:0]  M_PWR    = 8'hF8, V_PWR    = 8'h28;
  localparam logic [7:0]  M_ADV    = 8'hFE, V_ADV    = 8'h30;
  localparam logic [7:0]  M_SCROLL = 8'hC0, V_SCROLL = 8'h40;
  localparam logic [7:0]  M_GAIN   = 8'hFF, V_GAIN   = 8'h81;
  localparam logic [7:0]  M_STEP   = 8'hF8, V_STEP   = 8'h88;
  localparam logic [7:0]  M_FROZEN = 8'hF0, V_FROZEN = 8'h90;
  localparam logic [7:0]  M_ALLON  = 8'hFE, V_ALLON  = 8'hA4;
  localparam logic [7:0]  M_INV    = 8'hFE, V_INV    = 8'hA6;
  localparam logic [7:0]  M_DISP   = 8'hFE, V_DISP   = 8'hAE;
  localparam logic [7:0]  M_PAGE   = 8'hF0, V_PAGE   = 8'hB0;
  localparam logic [7:0]  M_MAP    = 8'hF0, V_MAP    = 8'hC0;
  localparam logic [7:0]  M_SYSRST = 8'hFF, V_SYSRST = 8'hE2;
  localparam logic [7:0]  M_TEST   = 8'hFC, V_TEST   = 8'hE4;
  localparam logic [7:0]  M_BIAS   = 8'hFC, V_BIAS   = 8'hE8;
  localparam logic [7:0]  M_CURCLR = 8'hFF, V_CURCLR = 8'hEE;
  localparam logic [7:0]  M_CURSET = 8'hFF, V_CURSET = 8'hEF;
  localparam logic [7:0]  STEP_RSV_CLR = 8'hFD;
  // Reset values
  localparam logic        MUX_RST   = 1'b1;
  localparam logic [1:0]  SLOPE_RST = 2'h0;
  localparam logic [2:0]  PWR_RST   = 3'h5;
  localparam logic [1:0]  GAIN_RST  = 2'h3;
  localparam logic [5:0]  TRIM_RST  = 6'h00;
  localparam logic [2:0]  STEP_RST  = 3'h1;
  localparam logic [1:0]  BIAS_RST  = 2'h2;
  localparam logic [7:0]  BUS_IDLE  = 8'hFF;
  // Soft reset duration
  localparam int unsigned RESET_TIME_MS        = 15;
  localparam int unsigned CLK_KHZ              = 250000;
  localparam int unsigned RESET_CYCLES_DEFAULT = RESET_TIME_MS * CLK_KHZ;
  localparam int unsigned RST_CNT_W            = 22;
  // Host bridge register map
  localparam logic [7:0]  OFS_CMD  = 8'h00;
  localparam logic [7:0]  OFS_STAT = 8'h04;
  localparam logic [1:0]  KIND_CMD = 2'h0, KIND_WR = 2'h1, KIND_RD = 2'h2, KIND_STAT = 2'h3;

  function automatic logic op_is(input logic [7:0] op, input logic [7:0] m, input logic [7:0] v);
    return (op & m) == v;
  endfunction

  function automatic logic takes_param(input logic [7:0] op);
    return op_is(op, M_GAIN, V_GAIN) | op_is(op, M_ADV, V_ADV) | op_is(op, M_TEST, V_TEST);
  endfunction
endpackage

// [hw/lcd_bus_if.sv]
// Parallel 8-bit link between host bridge and display controller
`timescale 1ns/1ps
interface lcd_bus_if;
  logic       cs;
  logic       cd;
  logic       rw;
  logic       en;
  logic [7:0] host_db_out;
  logic       host_db_oe;
  logic [7:0] dev_db_out;
  logic       dev_db_oe;
  logic [7:0] db;

  assign db = dev_db_oe ? dev_db_out : (host_db_oe ? host_db_out : lcd_cmd_pkg::BUS_IDLE);

  modport device (input cs, cd, rw, en, db, output dev_db_out, dev_db_oe);
  modport host   (output cs, cd, rw, en, host_db_out, host_db_oe, input db);
endinterface

// [hw/lcd_dev_end.sv]
// Display controller end: command decoder, RAM pointers, settings and display RAM
`timescale 1ns/1ps
module lcd_dev_end #(
  parameter int unsigned RESET_CYCLES = lcd_cmd_pkg::RESET_CYCLES_DEFAULT
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  lcd_bus_if.device       bus,
  input  wire logic [3:0] scan_bank,
  input  wire logic [7:0] scan_col,
  output logic [7:0]      scan_byte,
  output logic [7:0]      column_pointer,
  output logic [3:0]      row_bank_pointer,
  output logic [3:0]      ram_step_control,
  output logic            multiplex_select,
  output logic [1:0]      temp_slope,
  output logic [2:0]      panel_power_setting,
  output logic [5:0]      scroll_offset,
  output logic [1:0]      voltage_gain,
  output logic [5:0]      voltage_trim,
  output logic [2:0]      display_control_bits,
  output logic [3:0]      frozen_row_count,
  output logic [3:0]      mapping_control,
  output logic [1:0]      bias_select,
  output logic            internal_busy,
  output logic            reset_active_flag
);
  logic [7:0]                        ram [lcd_cmd_pkg::PAGES][lcd_cmd_pkg::COLS];
  logic [7:0]                        col_reg, col_next, saved_col_reg;
  logic [3:0]                        page_reg, page_next;
  logic                              cursor_reg, auto_wrap_reg, dir_reg;
  logic                              mux_reg, row_mirror_reg, column_mirror_reg, bit_order_swap_reg;
  logic [1:0]                        slope_reg, gain_reg, bias_reg;
  logic [2:0]                        power_reg, disp_reg;
  logic [5:0]                        scroll_reg, trim_reg;
  logic [3:0]                        frozen_reg;
  logic                              param_pending_reg, param_gain_reg;
  logic                              rst_active_reg;
  logic [lcd_cmd_pkg::RST_CNT_W-1:0] rst_cnt_reg;
  logic [7:0]                        rd_reg, scan_reg;
  logic                              rd_oe_reg;
  logic [7:0]                        op, ram_col, wr_byte, status_byte;
  logic                              take, acc, cmd_wr, data_wr, data_rd, stat_rd, new_cmd, param_wr, step, soft_go;
  function automatic logic [7:0] swap_bits(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7-i];
    end
    return r;
  endfunction
  assign op       = bus.db;
  assign take     = bus.cs & bus.en;
  assign acc      = take & ~rst_active_reg;
  assign cmd_wr   = acc & ~bus.cd & ~bus.rw;
  assign data_wr  = acc & bus.cd & ~bus.rw;
  assign data_rd  = acc & bus.cd & bus.rw;
  assign stat_rd  = take & ~bus.cd & bus.rw;
  assign param_wr = cmd_wr & param_pending_reg;
  assign new_cmd  = cmd_wr & ~param_pending_reg;
  assign soft_go  = new_cmd & lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_SYSRST, lcd_cmd_pkg::V_SYSRST);
  assign step     = data_wr | (data_rd & ~cursor_reg);
  assign ram_col  = column_mirror_reg ? 8'(lcd_cmd_pkg::COL_LAST - col_reg) : col_reg;
  assign wr_byte  = bit_order_swap_reg ? swap_bits(op) : op;
  assign status_byte = {internal_busy, column_mirror_reg, disp_reg[2], rst_active_reg,
                        auto_wrap_reg, gain_reg, 1'b1};
  always_comb begin
    col_next  = col_reg;
    page_next = page_reg;
    if (col_reg != lcd_cmd_pkg::COL_LAST) begin
      col_next = 8'(col_reg + 8'h01);
    end else if (auto_wrap_reg && !cursor_reg) begin
      col_next  = lcd_cmd_pkg::COL_FIRST;
      page_next = dir_reg ? 4'(page_reg - lcd_cmd_pkg::PAGE_ONE) : 4'(page_reg + lcd_cmd_pkg::PAGE_ONE);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_pending_reg <= 1'b0;
      param_gain_reg    <= 1'b0;
    end else if (param_wr) begin
      param_pending_reg <= 1'b0;
    end else if (new_cmd) begin
      param_pending_reg <= lcd_cmd_pkg::takes_param(op);
      param_gain_reg    <= lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_GAIN, lcd_cmd_pkg::V_GAIN);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_active_reg <= 1'b0;
      rst_cnt_reg    <= '0;
    end else if (soft_go) begin
      rst_active_reg <= 1'b1;
      rst_cnt_reg    <= lcd_cmd_pkg::RST_CNT_W'(RESET_CYCLES - 1);
    end else if (rst_active_reg) begin
      rst_active_reg <= rst_cnt_reg != '0;
      rst_cnt_reg    <= rst_cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_reg       <= lcd_cmd_pkg::COL_FIRST;
      page_reg      <= lcd_cmd_pkg::PAGE_FIRST;
      cursor_reg    <= 1'b0;
      saved_col_reg <= lcd_cmd_pkg::COL_FIRST;
    end else if (soft_go) begin
      col_reg    <= lcd_cmd_pkg::COL_FIRST;
      page_reg   <= lcd_cmd_pkg::PAGE_FIRST;
      cursor_reg <= 1'b0;
    end else if (step) begin
      col_reg  <= col_next;
      page_reg <= page_next;
    end else if (new_cmd) begin
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_COL_LO, lcd_cmd_pkg::V_COL_LO)) begin
        col_reg[3:0] <= op[3:0];
      end else if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_COL_HI, lcd_cmd_pkg::V_COL_HI)) begin
        col_reg[7:4] <= op[3:0];
      end else if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_PAGE, lcd_cmd_pkg::V_PAGE)) begin
        page_reg <= op[3:0];
      end else if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_CURSET, lcd_cmd_pkg::V_CURSET)) begin
        cursor_reg    <= 1'b1;
        saved_col_reg <= col_reg;
      end else if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_CURCLR, lcd_cmd_pkg::V_CURCLR)) begin
        cursor_reg <= 1'b0;
        col_reg    <= saved_col_reg;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_reg            <= lcd_cmd_pkg::MUX_RST;
      slope_reg          <= lcd_cmd_pkg::SLOPE_RST;
      power_reg          <= lcd_cmd_pkg::PWR_RST;
      scroll_reg         <= '0;
      gain_reg           <= lcd_cmd_pkg::GAIN_RST;
      trim_reg           <= lcd_cmd_pkg::TRIM_RST;
      {dir_reg, auto_wrap_reg} <= {lcd_cmd_pkg::STEP_RST[2], lcd_cmd_pkg::STEP_RST[0]};
      disp_reg           <= '0;
      frozen_reg         <= '0;
      row_mirror_reg     <= 1'b0;
      column_mirror_reg  <= 1'b0;
      bit_order_swap_reg <= 1'b0;
      bias_reg           <= lcd_cmd_pkg::BIAS_RST;
    end else if (soft_go) begin
      mux_reg            <= lcd_cmd_pkg::MUX_RST;
      slope_reg          <= lcd_cmd_pkg::SLOPE_RST;
      power_reg          <= lcd_cmd_pkg::PWR_RST;
      scroll_reg         <= '0;
      gain_reg           <= lcd_cmd_pkg::GAIN_RST;
      trim_reg           <= lcd_cmd_pkg::TRIM_RST;
      {dir_reg, auto_wrap_reg} <= {lcd_cmd_pkg::STEP_RST[2], lcd_cmd_pkg::STEP_RST[0]};
      disp_reg           <= '0;
      frozen_reg         <= '0;
      row_mirror_reg     <= 1'b0;
      column_mirror_reg  <= 1'b0;
      bit_order_swap_reg <= 1'b0;
      bias_reg           <= lcd_cmd_pkg::BIAS_RST;
    end else if (param_wr && param_gain_reg) begin
      gain_reg <= op[7:6];
      trim_reg <= op[5:0];
    end else if (new_cmd) begin
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_MUX, lcd_cmd_pkg::V_MUX)) begin
        {mux_reg, slope_reg} <= op[2:0];
      end
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_PWR, lcd_cmd_pkg::V_PWR)) begin
        power_reg <= op[2:0];
      end
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_SCROLL, lcd_cmd_pkg::V_SCROLL)) begin
        scroll_reg <= op[5:0];
      end
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_STEP, lcd_cmd_pkg::V_STEP)) begin
        {dir_reg, auto_wrap_reg} <= {op[2], op[0]};
      end
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_ALLON, lcd_cmd_pkg::V_ALLON)) begin
        disp_reg[1] <= op[0];
      end
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_INV, lcd_cmd_pkg::V_INV)) begin
        disp_reg[0] <= op[0];
      end
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_DISP, lcd_cmd_pkg::V_DISP)) begin
        disp_reg[2] <= op[0];
      end
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_FROZEN, lcd_cmd_pkg::V_FROZEN)) begin
        frozen_reg <= op[3:0];
      end
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_MAP, lcd_cmd_pkg::V_MAP)) begin
        {row_mirror_reg, column_mirror_reg, bit_order_swap_reg} <= {op[3], op[2], op[0]};
      end
      if (lcd_cmd_pkg::op_is(op, lcd_cmd_pkg::M_BIAS, lcd_cmd_pkg::V_BIAS)) begin
        bias_reg <= op[1:0];
      end
    end
  end
  always_ff @(posedge pclk) begin
    if (data_wr && ram_col <= lcd_cmd_pkg::COL_LAST) begin
      ram[page_reg][ram_col] <= wr_byte;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_reg    <= '0;
      rd_oe_reg <= 1'b0;
    end else begin
      rd_oe_reg <= data_rd | stat_rd;
      if (stat_rd) begin
        rd_reg <= status_byte;
      end else if (data_rd) begin
        rd_reg <= (ram_col <= lcd_cmd_pkg::COL_LAST) ? ram[page_reg][ram_col] : '0;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_reg <= '0;
    end else if (!disp_reg[2]) begin
      scan_reg <= '0;
    end else if (disp_reg[1]) begin
      scan_reg <= '1;
    end else if (scan_col <= lcd_cmd_pkg::COL_LAST) begin
      scan_reg <= disp_reg[0] ? ~ram[scan_bank][scan_col] : ram[scan_bank][scan_col];
    end else begin
      scan_reg <= '0;
    end
  end
  assign bus.dev_db_out       = rd_reg;
  assign bus.dev_db_oe        = rd_oe_reg;
  assign scan_byte            = scan_reg;
  assign column_pointer       = col_reg;
  assign row_bank_pointer     = page_reg;
  assign ram_step_control     = {cursor_reg, dir_reg, 1'b0, auto_wrap_reg};
  assign multiplex_select     = mux_reg;
  assign temp_slope           = slope_reg;
  assign panel_power_setting  = power_reg;
  assign scroll_offset        = scroll_reg;
  assign voltage_gain         = gain_reg;
  assign voltage_trim         = trim_reg;
  assign display_control_bits = disp_reg;
  assign frozen_row_count     = frozen_reg;
  assign mapping_control      = {row_mirror_reg, column_mirror_reg, 1'b0, bit_order_swap_reg};
  assign bias_select          = bias_reg;
  assign internal_busy        = rst_active_reg;
  assign reset_active_flag    = rst_active_reg;
endmodule

// [hw/lcd_host_end.sv]
// Host end: APB slave that turns register writes into link transfers
`timescale 1ns/1ps
module lcd_host_end #(
  parameter int unsigned RESET_WAIT = lcd_cmd_pkg::RESET_CYCLES_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  lcd_bus_if.host          bus
);
  typedef enum logic [3:0] {
    H_IDLE    = 4'b0001,
    H_STROBE  = 4'b0010,
    H_CAPTURE = 4'b0100,
    H_RSTWAIT = 4'b1000
  } host_state_t;

  host_state_t                       state_reg, state_next;
  logic [7:0]                        byte_reg, rd_byte_reg, out_byte;
  logic [1:0]                        kind_reg;
  logic                              param_next_reg, sent_reset_reg;
  logic [lcd_cmd_pkg::RST_CNT_W-1:0] wait_reg;
  logic                              acc, cmd_hit, stat_hit, bad_col, go, is_read;

  assign acc      = psel & penable;
  assign cmd_hit  = paddr == lcd_cmd_pkg::OFS_CMD;
  assign stat_hit = paddr == lcd_cmd_pkg::OFS_STAT;
  // Column high nibble beyond the last column is refused
  assign bad_col  = pwdata[9:8] == lcd_cmd_pkg::KIND_CMD && !param_next_reg &&
                    lcd_cmd_pkg::op_is(pwdata[7:0], lcd_cmd_pkg::M_COL_HI, lcd_cmd_pkg::V_COL_HI) &&
                    pwdata[3:0] > lcd_cmd_pkg::COL_HI_MAX;
  assign go       = acc & pwrite & cmd_hit & (state_reg == H_IDLE) & ~bad_col;
  assign is_read  = kind_reg[1];

  // Reserved step-control bit forced low unless the byte is a parameter
  always_comb begin
    out_byte = pwdata[7:0];
    if (pwdata[9:8] == lcd_cmd_pkg::KIND_CMD && !param_next_reg &&
        lcd_cmd_pkg::op_is(pwdata[7:0], lcd_cmd_pkg::M_STEP, lcd_cmd_pkg::V_STEP)) begin
      out_byte = pwdata[7:0] & lcd_cmd_pkg::STEP_RSV_CLR;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      H_IDLE: begin
        if (go) begin
          state_next = H_STROBE;
        end
      end
      H_STROBE: begin
        state_next = H_CAPTURE;
      end
      H_CAPTURE: begin
        state_next = sent_reset_reg ? H_RSTWAIT : H_IDLE;
      end
      H_RSTWAIT: begin
        if (wait_reg == '0) begin
          state_next = H_IDLE;
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= H_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latched request and two-byte tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_reg       <= '0;
      kind_reg       <= lcd_cmd_pkg::KIND_CMD;
      param_next_reg <= 1'b0;
      sent_reset_reg <= 1'b0;
    end else if (go) begin
      byte_reg <= out_byte;
      kind_reg <= pwdata[9:8];
      if (pwdata[9:8] == lcd_cmd_pkg::KIND_CMD) begin
        param_next_reg <= ~param_next_reg & lcd_cmd_pkg::takes_param(pwdata[7:0]);
        sent_reset_reg <= ~param_next_reg &
                          lcd_cmd_pkg::op_is(pwdata[7:0], lcd_cmd_pkg::M_SYSRST, lcd_cmd_pkg::V_SYSRST);
      end else begin
        sent_reset_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= '0;
    end else if (state_reg == H_CAPTURE) begin
      wait_reg <= lcd_cmd_pkg::RST_CNT_W'(RESET_WAIT - 1);
    end else if (state_reg == H_RSTWAIT && wait_reg != '0) begin
      wait_reg <= wait_reg - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_byte_reg <= '0;
    end else if (state_reg == H_CAPTURE && is_read) begin
      rd_byte_reg <= bus.db;
    end
  end

  // Link drive: one strobe cycle per transfer
  assign bus.cs          = state_reg == H_STROBE;
  assign bus.en          = state_reg == H_STROBE;
  assign bus.cd          = kind_reg == lcd_cmd_pkg::KIND_WR || kind_reg == lcd_cmd_pkg::KIND_RD;
  assign bus.rw          = is_read;
  assign bus.host_db_out = byte_reg;
  assign bus.host_db_oe  = state_reg == H_STROBE && !is_read;

  assign pready  = 1'b1;
  assign pslverr = acc & ((~cmd_hit & ~stat_hit) | (pwrite & cmd_hit & ~go) | (pwrite & stat_hit));
  assign prdata  = (acc && !pwrite && stat_hit) ?
                   {16'h0000, rd_byte_reg, 6'h00, param_next_reg, state_reg != H_IDLE} : 32'h0000_0000;
endmodule

// [bench/lcd_link_properties.sv]
// Link checks between the host end and the display end
`timescale 1ns/1ps
module lcd_link_properties (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cs,
  input wire logic       cd,
  input wire logic       rw,
  input wire logic       en,
  input wire logic [7:0] host_db_out,
  input wire logic       host_db_oe,
  input wire logic [7:0] dev_db_out,
  input wire logic       dev_db_oe,
  input wire logic [7:0] db
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_stat_req;
    cs && en && !cd && rw;
  endsequence
  sequence s_wr_req;
    cs && en && !rw;
  endsequence
  a_status_answer: assert property (s_stat_req |=> dev_db_oe && dev_db_out[0]) else $error("status answer missing");
  a_answer_single: assert property (dev_db_oe |=> !dev_db_oe) else $error("answer held too long");
  a_answer_asked: assert property (dev_db_oe |-> $past(cs) && $past(en) && $past(rw)) else $error("unasked answer");
  a_strobe_pulse: assert property (en |=> !en) else $error("strobe longer than one cycle");
  a_write_drive: assert property (s_wr_req |-> host_db_oe && db == host_db_out) else $error("write byte not on bus");
  a_answer_wire: assert property (dev_db_oe |-> db == dev_db_out) else $error("answer not on bus");
  a_no_clash: assert property (!(dev_db_oe && host_db_oe)) else $error("both ends drive bus");
  a_write_silent: assert property (s_wr_req |=> !dev_db_oe) else $error("answer after write");
endmodule

// [bench/test_lcd_controller_command_decoder.sv]
// Self-checking bench joining host end and display end
`timescale 1ns/1ps
module test_lcd_controller_command_decoder;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, mux, busy, rsa;
  logic [7:0]  paddr, col, sb;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pg, stp, frz, mapc;
  logic [5:0]  scroll, trim;
  logic [2:0]  pwr, dc;
  logic [1:0]  slope, gain, bias;
  int          n_mismatch = 0;
  int          comparisons = 0;
  lcd_bus_if bus ();
  lcd_dev_end #(.RESET_CYCLES(20)) u_lcd_dev_end (.pclk(pclk), .presetn(presetn), .bus(bus), .scan_bank(4'h2),
    .scan_col(8'h05), .scan_byte(sb), .column_pointer(col), .row_bank_pointer(pg), .ram_step_control(stp),
    .multiplex_select(mux), .temp_slope(slope), .panel_power_setting(pwr), .scroll_offset(scroll),
    .voltage_gain(gain), .voltage_trim(trim), .display_control_bits(dc), .frozen_row_count(frz),
    .mapping_control(mapc), .bias_select(bias), .internal_busy(busy), .reset_active_flag(rsa));
  lcd_host_end #(.RESET_WAIT(20)) u_lcd_host_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
  lcd_link_properties u_lcd_link_properties (.pclk(pclk), .presetn(presetn), .cs(bus.cs), .cd(bus.cd), .rw(bus.rw),
    .en(bus.en), .host_db_out(bus.host_db_out), .host_db_oe(bus.host_db_oe), .dev_db_out(bus.dev_db_out),
    .dev_db_oe(bus.dev_db_oe), .db(bus.db));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic results();
    $display("Counts: %0d compared, %0d mismatched", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      results();
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, lcd_cmd_pkg::OFS_STAT, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic xfer(input logic [1:0] k, input logic [7:0] b);
    apb(1'b1, lcd_cmd_pkg::OFS_CMD, {22'h0, k, b});
    repeat (3) @(posedge pclk);
    idle();
  endtask
  task automatic cmds(input logic [7:0] q[$]);
    foreach (q[i]) begin
      xfer(2'h0, q[i]);
    end
  endtask
  task automatic rd(input logic [7:0] e);
    xfer(2'h2, 8'h00);
    chk(rdat[15:8], e);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({mux, slope, pwr, gain, trim, stp, bias}, {1'b1, 2'h0, 3'h5, 2'h3, 6'h00, 4'h1, 2'h2});
    xfer(2'h3, 8'h00);
    chk(rdat[15:8], 8'h0F);
    $display("Test reset_state done");
    cmds('{8'h22, 8'h2B, 8'h7F, 8'hEB, 8'h9A, 8'hE3, 8'h81, 8'h45, 8'h30, 8'hB3});
    chk({mux, slope, pwr, scroll, bias, frz}, {1'b0, 2'h2, 3'h3, 6'h3F, 2'h3, 4'hA});
    chk({gain, trim, pg}, {2'h1, 6'h05, 4'h0});
    $display("Test settings done");
    cmds('{8'hB2, 8'h05, 8'h10});
    xfer(2'h1, 8'hA5);
    chk({pg, col}, {4'h2, 8'h06});
    cmds('{8'h05, 8'hAF, 8'hA7});
    rd(8'hA5);
    chk({dc, sb}, {3'h5, 8'h5A});
    cmds('{8'hA5});
    chk({dc, sb}, {3'h7, 8'hFF});
    cmds('{8'hAE, 8'hA4, 8'hA6, 8'h05});
    chk({dc, sb}, {3'h0, 8'h00});
    rd(8'hA5);
    $display("Test ram_access done");
    cmds('{8'hC1, 8'h06, 8'h10});
    xfer(2'h1, 8'h01);
    cmds('{8'hC0, 8'h06});
    rd(8'h80);
    cmds('{8'hC4, 8'h00, 8'h10});
    xfer(2'h1, 8'h3C);
    cmds('{8'hC0, 8'h0F, 8'h1E});
    rd(8'h3C);
    $display("Test mapping done");
    cmds('{8'hBF, 8'h0E, 8'h1E, 8'h89});
    xfer(2'h1, 8'h00);
    xfer(2'h1, 8'h00);
    chk({pg, col}, {4'h0, 8'h00});
    cmds('{8'h8D, 8'h0F, 8'h1E});
    xfer(2'h1, 8'h00);
    chk({pg, col}, {4'hF, 8'h00});
    cmds('{8'h88, 8'h0F, 8'h1E});
    xfer(2'h1, 8'h00);
    chk(col, 8'hEF);
    $display("Test stepping done");
    cmds('{8'h00, 8'h11, 8'hEF});
    xfer(2'h2, 8'h00);
    chk({stp, col}, {4'h8, 8'h10});
    xfer(2'h1, 8'h00);
    chk(col, 8'h11);
    cmds('{8'hEE, 8'hCC});
    chk({stp, col, mapc}, {4'h0, 8'h10, 4'hC});
    xfer(2'h3, 8'h00);
    chk(rdat[15:8], 8'h43);
    $display("Test cursor_status done");
    apb(1'b1, lcd_cmd_pkg::OFS_CMD, 32'hE2);
    repeat (3) @(posedge pclk);
    chk({rsa, busy}, 2'h3);
    apb(1'b1, lcd_cmd_pkg::OFS_CMD, 32'hAF);
    chk(serr, 1'b1);
    idle();
    apb(1'b1, lcd_cmd_pkg::OFS_CMD, 32'h1F);
    chk(serr, 1'b1);
    chk({mux, dc, scroll, gain, mapc, col}, {1'b1, 3'h0, 6'h00, 2'h3, 4'h0, 8'h00});
    apb(1'b0, 8'h08, 32'h0);
    chk(serr, 1'b1);
    $display("Test soft_reset done");
    results();
  end
endmodule
